// ### verilog/odc_pkg.sv
package odc_pkg;
	// byte addresses of the configuration registers
	localparam logic [7:0] ADDR_DIV_HI   = 8'h60;
	localparam logic [7:0] ADDR_DIV_MID  = 8'h61;
	localparam logic [7:0] ADDR_DIV_LO   = 8'h62;
	localparam logic [7:0] ADDR_LEG_CTL  = 8'h63;
	localparam logic [7:0] ADDR_DELAY    = 8'h64;
	localparam logic [7:0] ADDR_ARR_CTL  = 8'h66;
	// reset values and read answer of an unmapped address
	localparam logic [7:0] RST_BYTE      = 8'h00;
	localparam logic [3:0] RST_ARR       = 4'h0;
	localparam logic [7:0] UNMAPPED_DATA = 8'h00;
	// writable bits of the leg register, the rest read as zero
	localparam logic [7:0] LEG_CTL_MASK  = 8'hC7;
	// field positions
	localparam int LEG_SRC_HI  = 7;
	localparam int LEG_SRC_LO  = 6;
	localparam int STRENGTH_HI = 2;
	localparam int COARSE_HI   = 5;
	localparam int FINE_HI     = 7;
	localparam int FINE_LO     = 6;
	localparam int SUPPLY_HI   = 4;
	localparam int SUPPLY_LO   = 3;
	// leg source codes
	localparam logic [1:0] LEG_SRC_SPLIT = 2'h0;
	localparam logic [1:0] LEG_SRC_TRUE  = 2'h1;
	// driver arrangement codes, {b3,b2,b1,b0}
	localparam logic [3:0] ARR_EXT_DIFF  = 4'h0;
	localparam logic [3:0] ARR_PULL_DN   = 4'h1;
	localparam logic [3:0] ARR_PULL_UP   = 4'h2;
	localparam logic [3:0] ARR_SE_POS    = 4'h4;
	localparam logic [3:0] ARR_SE_NEG    = 4'h8;
	localparam logic [3:0] ARR_SE_BOTH   = 4'hC;
	// timing
	localparam int DELAY_TAPS   = 64;
	localparam int FINE_STEP_PS = 30;
	// one leg pair of clock levels
	typedef struct packed {
		logic pos;
		logic neg;
	} odc_leg_t;
	// pad control derived from the arrangement code
	typedef struct packed {
		logic pos_oe;
		logic neg_oe;
		logic diff;
		logic pull_up;
		logic pull_dn;
	} odc_pad_t;
endpackage

// ### verilog/odc_delay_line.sv
`timescale 1ns/1ps
// tapped shift line; the tap comes out of a register
module odc_delay_line #(
	parameter int DEPTH = 64,
	parameter int SEL_W = 6
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst_n,
	input  wire logic             i_din,
	input  wire logic [SEL_W-1:0] i_sel,
	output logic                  o_dout
);
	// stage k holds input delayed k+1 clocks; the top code reads the last one
	logic [DEPTH-2:0] stage;     // no spare stage, so nothing sits unread
	logic             tap;       // selected tap before the output flop
	logic [6:0]       sel_age;   // clocks the select has been steady

	// one flop per stage
	genvar g;
	generate
		for (g = 0; g < DEPTH - 1; g++)
		begin : g_stage
			if (g == 0)
			begin : g_first
				always_ff @(posedge i_clk)
					stage[g] <= i_rst_n ? i_din : 1'b0;
			end
			else
			begin : g_rest
				always_ff @(posedge i_clk)
					stage[g] <= i_rst_n ? stage[g-1] : 1'b0;
			end
		end
	endgenerate

	// tap selection
	// select zero takes the live input, so relative delay equals the code
	assign tap = (i_sel == '0) ? i_din : stage[i_sel - 1'b1];

	// output register adds one clock common to every code
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			o_dout <= 1'b0;
		else
			o_dout <= tap;
	end

	// steady-select age, only the assertions read it
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n || (i_sel != $past(i_sel)))
			sel_age <= 7'h00;
		else if (sel_age != 7'h7F)
			sel_age <= sel_age + 7'h01;
	end

	// zero delay follows input one clock later
	tap_zero_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_sel == '0 && sel_age > 7'h02) |=> (o_dout == $past(i_din)))
		else $error("zero coarse delay not one clock");
	// longest delay is sixty-three clocks beyond zero
	tap_max_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_sel == 6'h3F && sel_age > 7'h42) |=> (o_dout == $past(i_din, 64)))
		else $error("max coarse delay wrong");
endmodule // odc_delay_line

// ### verilog/odc_top.sv
`timescale 1ns/1ps
// one clock output: divider, coarse delay, leg selection and pad control
// the reference clock stands in for the vco clock that times the coarse delay
module odc_top #(
	parameter int DIV_W = 24
) (
	input  wire logic             I_REF_CLK,
	input  wire logic             I_RST_N,
	input  wire logic [7:0]       I_REG_ADDR,
	input  wire logic             I_REG_WR,
	input  wire logic             I_REG_RD,
	input  wire logic [7:0]       I_REG_WDATA,
	output logic      [7:0]       O_REG_RDATA,
	output logic                  O_REG_RVALID,
	output logic      [DIV_W-1:0] O_DIVIDER_VALUE,
	output logic                  O_POS_LEG,
	output logic                  O_NEG_LEG,
	output logic                  O_POS_OE,
	output logic                  O_NEG_OE,
	output logic                  O_DIFF_MODE,
	output logic                  O_PULL_UP,
	output logic                  O_PULL_DOWN,
	output logic      [2:0]       O_DRIVE_STRENGTH,
	output logic      [5:0]       O_COARSE_DELAY,
	output logic      [1:0]       O_FINE_STEPS,
	output logic      [1:0]       O_SUPPLY_DEF
);
	// configuration registers
	logic [7:0]       div_hi;             // divider bits 23:16
	logic [7:0]       div_mid;            // divider bits 15:8
	logic [7:0]       div_lo;             // divider bits 7:0
	logic [7:0]       leg_ctl;            // leg source and drive strength
	logic [7:0]       output_delay_code;  // coarse, fine and supply bits
	logic [3:0]       arr_ctl;            // driver arrangement
	// write strobes
	logic             wr_hi;
	logic             wr_mid;
	logic             wr_lo;
	logic             wr_leg;
	logic             wr_delay;
	logic             wr_arr;
	// clock path
	logic [DIV_W-1:0] output_divider_value; // assembled ratio
	logic [DIV_W-1:0] half_cnt;             // clocks into the current half period
	logic             div_clk;              // divided clock before delay
	logic             true_clock_phase;     // delayed clock
	logic             complement_clock_phase;
	logic [1:0]       leg_src;
	odc_pkg::odc_leg_t next_leg;
	odc_pkg::odc_pad_t next_pad;
	logic [7:0]       rd_mux;

	// address decode
	assign wr_hi    = I_REG_WR && (I_REG_ADDR == odc_pkg::ADDR_DIV_HI);
	assign wr_mid   = I_REG_WR && (I_REG_ADDR == odc_pkg::ADDR_DIV_MID);
	assign wr_lo    = I_REG_WR && (I_REG_ADDR == odc_pkg::ADDR_DIV_LO);
	assign wr_leg   = I_REG_WR && (I_REG_ADDR == odc_pkg::ADDR_LEG_CTL);
	assign wr_delay = I_REG_WR && (I_REG_ADDR == odc_pkg::ADDR_DELAY);
	assign wr_arr   = I_REG_WR && (I_REG_ADDR == odc_pkg::ADDR_ARR_CTL);

	always_ff @(posedge I_REF_CLK)
	begin
		if (!I_RST_N)
		begin
			div_hi            <= odc_pkg::RST_BYTE;
			div_mid           <= odc_pkg::RST_BYTE;
			div_lo            <= odc_pkg::RST_BYTE;
			leg_ctl           <= odc_pkg::RST_BYTE;
			output_delay_code <= odc_pkg::RST_BYTE;
			arr_ctl           <= odc_pkg::RST_ARR;
		end
		else
		begin
			if (wr_hi)    div_hi  <= I_REG_WDATA;
			if (wr_mid)   div_mid <= I_REG_WDATA;
			if (wr_lo)    div_lo  <= I_REG_WDATA;
			// strength is stored as written; all ones is up to software
			if (wr_leg)   leg_ctl <= I_REG_WDATA & odc_pkg::LEG_CTL_MASK;
			if (wr_delay) output_delay_code <= I_REG_WDATA;
			if (wr_arr)   arr_ctl <= I_REG_WDATA[3:0];
		end
	end

	assign output_divider_value = {div_hi, div_mid, div_lo};

	// divider: each half period lasts ratio clocks; zero holds the clock low
	always_ff @(posedge I_REF_CLK)
	begin
		if (!I_RST_N || (output_divider_value == '0))
		begin
			half_cnt <= '0;
			div_clk  <= 1'b0;
		end
		else if (half_cnt >= output_divider_value - 1'b1)
		begin
			half_cnt <= '0;
			div_clk  <= ~div_clk;
		end
		else
			half_cnt <= half_cnt + 1'b1;
	end

	odc_delay_line #(
		.DEPTH (odc_pkg::DELAY_TAPS),
		.SEL_W (6)
	) u_delay (
		.i_clk   (I_REF_CLK),
		.i_rst_n (I_RST_N),
		.i_din   (div_clk),
		.i_sel   (output_delay_code[odc_pkg::COARSE_HI:0]),
		.o_dout  (true_clock_phase)
	);
	assign complement_clock_phase = ~true_clock_phase;

	// leg source selection, codes 10 and 11 both take the complement
	assign leg_src = leg_ctl[odc_pkg::LEG_SRC_HI:odc_pkg::LEG_SRC_LO];
	assign next_leg.pos = next_pad.diff ? true_clock_phase :
		(leg_src[1] ? complement_clock_phase : true_clock_phase);
	assign next_leg.neg = next_pad.diff ? complement_clock_phase :
		((leg_src == odc_pkg::LEG_SRC_SPLIT) ? complement_clock_phase :
		 (leg_src == odc_pkg::LEG_SRC_TRUE)  ? true_clock_phase :
		 complement_clock_phase);

	// arrangement decode; unlisted codes leave both legs undriven
	assign next_pad.diff    = (arr_ctl == odc_pkg::ARR_EXT_DIFF) ||
		(arr_ctl == odc_pkg::ARR_PULL_UP) || (arr_ctl == odc_pkg::ARR_PULL_DN);
	assign next_pad.pos_oe  = next_pad.diff || (arr_ctl == odc_pkg::ARR_SE_POS) ||
		(arr_ctl == odc_pkg::ARR_SE_BOTH);
	assign next_pad.neg_oe  = next_pad.diff || (arr_ctl == odc_pkg::ARR_SE_NEG) ||
		(arr_ctl == odc_pkg::ARR_SE_BOTH);
	assign next_pad.pull_up = (arr_ctl == odc_pkg::ARR_PULL_UP);
	assign next_pad.pull_dn = (arr_ctl == odc_pkg::ARR_PULL_DN);

	// registered pad outputs; a disabled leg is held low
	always_ff @(posedge I_REF_CLK)
	begin
		if (!I_RST_N)
		begin
			O_POS_LEG   <= 1'b0;
			O_NEG_LEG   <= 1'b0;
			O_POS_OE    <= 1'b0;
			O_NEG_OE    <= 1'b0;
			O_DIFF_MODE <= 1'b0;
			O_PULL_UP   <= 1'b0;
			O_PULL_DOWN <= 1'b0;
		end
		else
		begin
			O_POS_LEG   <= next_leg.pos & next_pad.pos_oe;
			O_NEG_LEG   <= next_leg.neg & next_pad.neg_oe;
			O_POS_OE    <= next_pad.pos_oe;
			O_NEG_OE    <= next_pad.neg_oe;
			O_DIFF_MODE <= next_pad.diff;
			O_PULL_UP   <= next_pad.pull_up;
			O_PULL_DOWN <= next_pad.pull_dn;
		end
	end

	// field outputs straight from the register flops
	// fine step count for the analog trim
	assign O_FINE_STEPS     = output_delay_code[odc_pkg::FINE_HI:odc_pkg::FINE_LO];
	// supply field shares bits with the coarse code
	assign O_SUPPLY_DEF     = output_delay_code[odc_pkg::SUPPLY_HI:odc_pkg::SUPPLY_LO];
	assign O_COARSE_DELAY   = output_delay_code[odc_pkg::COARSE_HI:0];
	assign O_DRIVE_STRENGTH = leg_ctl[odc_pkg::STRENGTH_HI:0];
	assign O_DIVIDER_VALUE  = output_divider_value;

	// read-back mux, unmapped reads give zero
	assign rd_mux =
		(I_REG_ADDR == odc_pkg::ADDR_DIV_HI)  ? div_hi :
		(I_REG_ADDR == odc_pkg::ADDR_DIV_MID) ? div_mid :
		(I_REG_ADDR == odc_pkg::ADDR_DIV_LO)  ? div_lo :
		(I_REG_ADDR == odc_pkg::ADDR_LEG_CTL) ? leg_ctl :
		(I_REG_ADDR == odc_pkg::ADDR_DELAY)   ? output_delay_code :
		(I_REG_ADDR == odc_pkg::ADDR_ARR_CTL) ? {4'h0, arr_ctl} :
		odc_pkg::UNMAPPED_DATA;

	// read data one clock after the strobe
	always_ff @(posedge I_REF_CLK)
	begin
		if (!I_RST_N)
		begin
			O_REG_RDATA  <= 8'h00;
			O_REG_RVALID <= 1'b0;
		end
		else
		begin
			O_REG_RVALID <= I_REG_RD;
			if (I_REG_RD)
				O_REG_RDATA <= rd_mux;
		end
	end

	// sequences for write-then-read
	sequence s_wr_mid;
		I_REG_WR && !I_REG_RD && I_REG_ADDR == odc_pkg::ADDR_DIV_MID;
	endsequence
	sequence s_rd_mid;
		!I_REG_WR && I_REG_RD && I_REG_ADDR == odc_pkg::ADDR_DIV_MID;
	endsequence

	div_high_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
		wr_hi |=> (O_DIVIDER_VALUE[23:16] == $past(I_REG_WDATA)))
		else $error("divider high byte misplaced");
	div_low_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
		(wr_lo && !wr_hi) |=> (O_DIVIDER_VALUE[7:0] == $past(I_REG_WDATA)))
		else $error("divider low byte misplaced");
	leg_true_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
		(arr_ctl == odc_pkg::ARR_SE_BOTH && leg_src == 2'h1) |=> (O_POS_LEG == O_NEG_LEG))
		else $error("both legs not on true phase");
	leg_split_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
		(arr_ctl == odc_pkg::ARR_SE_BOTH && leg_src == 2'h0) |=> (O_POS_LEG != O_NEG_LEG))
		else $error("legs not split true and complement");
	fine_write_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
		wr_delay |=> (O_FINE_STEPS == $past(I_REG_WDATA[7:6])))
		else $error("fine steps not from bits 7:6");
	supply_write_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
		wr_delay |=> (O_SUPPLY_DEF == $past(I_REG_WDATA[4:3])))
		else $error("supply field not from bits 4:3");
	se_pos_only_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
		(arr_ctl == odc_pkg::ARR_SE_POS) |=> (O_POS_OE && !O_NEG_OE && !O_DIFF_MODE && !O_NEG_LEG))
		else $error("positive-only arrangement wrong");
	pull_up_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
		(arr_ctl == odc_pkg::ARR_PULL_UP) |=> (O_PULL_UP && !O_PULL_DOWN && O_DIFF_MODE))
		else $error("pull-up arrangement wrong");
	reset_zero_a: assert property (@(posedge I_REF_CLK)
		!I_RST_N |=> (O_DIVIDER_VALUE == '0 && O_FINE_STEPS == 2'h0 && !O_REG_RVALID))
		else $error("fields not zero after reset");
	read_back_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
		s_wr_mid ##1 s_rd_mid |=> (O_REG_RVALID && O_REG_RDATA == $past(I_REG_WDATA, 2)))
		else $error("read back differs from write");
endmodule // odc_top

// ### test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic        I_REF_CLK;        // 20 MHz reference
	logic        I_RST_N;          // synchronous reset, active low
	logic [7:0]  I_REG_ADDR;       // register byte address
	logic        I_REG_WR;         // write strobe
	logic        I_REG_RD;         // read strobe
	logic [7:0]  I_REG_WDATA;      // write data
	logic [7:0]  O_REG_RDATA;
	logic        O_REG_RVALID;
	logic [23:0] O_DIVIDER_VALUE;
	logic        O_POS_LEG;
	logic        O_NEG_LEG;
	logic        O_POS_OE;
	logic        O_NEG_OE;
	logic        O_DIFF_MODE;
	logic        O_PULL_UP;
	logic        O_PULL_DOWN;
	logic [2:0]  O_DRIVE_STRENGTH;
	logic [5:0]  O_COARSE_DELAY;
	logic [1:0]  O_FINE_STEPS;
	logic [1:0]  O_SUPPLY_DEF;
	int          bad_count;        // mismatches seen
	int          total_checks;     // comparisons made
	int          cyc;              // falling edges since start
	logic [7:0]  shadow [0:255];   // expected register contents
	logic [7:0]  exp_q [$];        // expected read answers, oldest first
	logic [7:0]  seed;             // lfsr state
	// arrangement codes and expected {pos_oe,neg_oe,diff,pull_up,pull_dn}; 4'h3 is unlisted
	localparam logic [3:0] ARR_LIST [0:6] = '{odc_pkg::ARR_EXT_DIFF, odc_pkg::ARR_PULL_DN,
		odc_pkg::ARR_PULL_UP, odc_pkg::ARR_SE_POS, odc_pkg::ARR_SE_NEG, odc_pkg::ARR_SE_BOTH, 4'h3};
	localparam logic [4:0] PAD_EXP [0:6] = '{5'h1C, 5'h1D, 5'h1E, 5'h10, 5'h08, 5'h18, 5'h00};

	odc_top u_odc_top (.I_REF_CLK(I_REF_CLK), .I_RST_N(I_RST_N), .I_REG_ADDR(I_REG_ADDR),
		.I_REG_WR(I_REG_WR), .I_REG_RD(I_REG_RD), .I_REG_WDATA(I_REG_WDATA),
		.O_REG_RDATA(O_REG_RDATA), .O_REG_RVALID(O_REG_RVALID), .O_DIVIDER_VALUE(O_DIVIDER_VALUE),
		.O_POS_LEG(O_POS_LEG), .O_NEG_LEG(O_NEG_LEG), .O_POS_OE(O_POS_OE), .O_NEG_OE(O_NEG_OE),
		.O_DIFF_MODE(O_DIFF_MODE), .O_PULL_UP(O_PULL_UP), .O_PULL_DOWN(O_PULL_DOWN),
		.O_DRIVE_STRENGTH(O_DRIVE_STRENGTH), .O_COARSE_DELAY(O_COARSE_DELAY),
		.O_FINE_STEPS(O_FINE_STEPS), .O_SUPPLY_DEF(O_SUPPLY_DEF));

	// free running reference clock
	initial
	begin
		I_REF_CLK = 1'b0;
		forever #25 I_REF_CLK = ~I_REF_CLK;
	end

	// bits that read back; unmapped places keep nothing
	function automatic logic [7:0] rmask(input logic [7:0] a);
		case (a)
			8'h60, 8'h61, 8'h62, 8'h64: return 8'hFF;
			8'h63:                      return odc_pkg::LEG_CTL_MASK;
			8'h66:                      return 8'h0F;
			default:                    return 8'h00;
		endcase
	endfunction

	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	task automatic chk(input logic ok, input string msg);
		total_checks++;
		if (ok !== 1'b1)
		begin
			bad_count++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask

	// each bus task drives at a falling edge and leaves one edge for the strobe to be taken
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		I_REG_ADDR  = a;
		I_REG_WDATA = d;
		I_REG_WR    = 1'b1;
		I_REG_RD    = 1'b0;
		shadow[a]   = d & rmask(a);
		@(negedge I_REF_CLK);
	endtask

	task automatic rd(input logic [7:0] a);
		I_REG_ADDR = a;
		I_REG_RD   = 1'b1;
		I_REG_WR   = 1'b0;
		exp_q.push_back(shadow[a]);
		@(negedge I_REF_CLK);
	endtask

	task automatic idle(input int n);
		I_REG_WR = 1'b0;
		I_REG_RD = 1'b0;
		repeat (n) @(negedge I_REF_CLK);
	endtask

	task automatic do_reset();
		I_RST_N = 1'b0;
		idle(5);
		I_RST_N = 1'b1;
		for (int a = 0; a < 256; a++) shadow[a] = 8'h00;
	endtask

	// reads every mapped place plus two unmapped ones
	task automatic read_all();
		foreach (ARR_LIST[j]) rd(8'h60 + 8'(j));
		rd(8'h6F);
	endtask

	// phase of the next positive leg rise within the 80 cycle divider period
	task automatic rise_phase(output int p);
		int n;
		n = 0;
		while ((O_POS_LEG !== 1'b0) && (n < 300))
		begin
			@(negedge I_REF_CLK);
			n++;
		end
		while ((O_POS_LEG !== 1'b1) && (n < 300))
		begin
			@(negedge I_REF_CLK);
			n++;
		end
		chk(n < 300, "no rising edge on positive leg");
		p = cyc % 80;
	endtask

	task results();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if ((bad_count == 0) && (total_checks > 0))
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// read answers are matched against the oldest expectation
	always @(negedge I_REF_CLK)
	begin
		cyc <= cyc + 1;
		if (O_REG_RVALID === 1'b1)
		begin
			if (exp_q.size() == 0)
				chk(1'b0, "read answer without request");
			else
				chk(O_REG_RDATA === exp_q.pop_front(), "read data");
		end
	end

	// watchdog, far beyond the several hundred cycles the tests need
	initial
	begin
		#1000000;
		bad_count++;
		results();
	end

	initial
	begin
		logic [7:0] d;
		int         p0;
		int         p1;
		int         tg;
		logic       lp;
		bad_count = 0;
		total_checks = 0;
		cyc = 0;
		seed = 8'h11;
		I_RST_N = 1'b0;
		I_REG_ADDR = 8'h00;
		I_REG_WDATA = 8'h00;
		I_REG_WR = 1'b0;
		I_REG_RD = 1'b0;
		@(negedge I_REF_CLK);
		do_reset();
		read_all();
		// unmapped writes must leave nothing behind
		wr(8'h65, 8'hA5);
		wr(8'h6F, 8'h5A);
		read_all();
		for (int i = 0; i < 4; i++)
		begin
			for (int b = 0; b < 3; b++)
			begin
				seed = lfsr(seed);
				wr(8'h60 + 8'(b), seed);
			end
			idle(2);
			chk(O_DIVIDER_VALUE === {shadow[8'h60], shadow[8'h61], shadow[8'h62]}, "div");
		end
		// every fine code with random coarse and supply bits
		for (int i = 0; i < 4; i++)
		begin
			seed = lfsr(seed);
			d = {i[1:0], seed[5:0]};
			if (d[4:3] == 2'b11)
				d[4] = 1'b0;
			wr(8'h64, d);
			idle(2);
			chk(O_COARSE_DELAY === d[5:0], "coarse delay");
			chk(O_FINE_STEPS === d[7:6], "fine steps");
			chk(O_SUPPLY_DEF === d[4:3], "supply definition");
		end
		// write then read back in the very next cycle
		seed = lfsr(seed);
		wr(8'h61, seed);
		rd(8'h61);
		wr(8'h63, 8'hFF);
		idle(2);
		chk(O_DRIVE_STRENGTH === 3'b111, "drive strength");
		read_all();
		// run the divider fast with no delay for the pad checks
		wr(8'h60, 8'h00);
		wr(8'h61, 8'h00);
		wr(8'h62, 8'h03);
		wr(8'h64, 8'h00);
		foreach (ARR_LIST[j])
		begin
			wr(8'h66, {4'h0, ARR_LIST[j]});
			idle(4);
			chk({O_POS_OE, O_NEG_OE, O_DIFF_MODE, O_PULL_UP, O_PULL_DOWN} === PAD_EXP[j], "pad");
			chk(((O_POS_OE === 1'b1) || (O_POS_LEG === 1'b0)), "idle pos leg");
			chk(((O_NEG_OE === 1'b1) || (O_NEG_LEG === 1'b0)), "idle neg leg");
		end
		// every leg source code on both single-ended legs, then one differential case
		for (int s = 0; s < 5; s++)
		begin
			wr(8'h66, (s < 4) ? 8'h0C : 8'h00);
			wr(8'h63, {2'(s), 6'h07});
			idle(8);
			tg = 0;
			lp = O_POS_LEG;
			repeat (12)
			begin
				@(negedge I_REF_CLK);
				tg += (O_POS_LEG !== lp) ? 1 : 0;
				lp = O_POS_LEG;
				chk((s == 0 || s == 4) ? (O_POS_LEG === ~O_NEG_LEG) : (O_POS_LEG === O_NEG_LEG), "legs");
			end
			chk(tg > 0, "leg clock not toggling");
		end
		// coarse delay at its top code, against code zero
		wr(8'h62, 8'h28);
		idle(100);
		rise_phase(p0);
		wr(8'h64, 8'h3F);
		idle(150);
		rise_phase(p1);
		chk(((p1 - p0 + 80) % 80) == 63, "coarse delay in cycles");
		// second reset in mid-run
		idle(2);
		do_reset();
		read_all();
		idle(4);
		chk(exp_q.size() == 0, "read answers missing");
		results();
	end
endmodule // tb_top
